// [verilog/host_bus_pkg.sv]
// ----------------------------------------------------------------------------
// host_bus_pkg: constants and types for the 8-bit multiplexed host-bus port
// ----------------------------------------------------------------------------
// assumes a single 40 MHz system clock and an external address latch on the bus
//
// Operation
// - port mode 0x2, host-bus mode 0x0 selects this
// - two config fields steer muxing and selects
// - eight data lines, freed pins carry address
// - bus cycles stretched slower for older logic
// - low address byte shares the data lines
// - latch strobe in address phase; latch holds
// - separate read and write data strobes
// - zero to two selects, one per access
// - select scheme field picks latch or selects
// - scheme 0 latch,1 one,2 two,3 latch+two
package host_bus_pkg;

  // --------------------------------------------------------------------------
  // configuration codes
  // --------------------------------------------------------------------------
  localparam logic [3:0] PORT_MODE_EIGHT_BIT_HOST_BUS = 4'h2;
  localparam logic [1:0] HB_MODE_MUXED = 2'h0;
  localparam logic [1:0] SCHEME_LATCH_ONLY = 2'h0;
  localparam logic [1:0] SCHEME_ONE_SELECT = 2'h1;
  localparam logic [1:0] SCHEME_TWO_SELECTS = 2'h2;
  localparam logic [1:0] SCHEME_LATCH_TWO_SELECTS = 2'h3;

  // --------------------------------------------------------------------------
  // pin positions on the shared port
  // --------------------------------------------------------------------------
  localparam int PIN_COUNT = 32;
  localparam int ADDR_WIDTH = 28;
  localparam int DATA_WIDTH = 8;
  localparam int PIN_HIGH_ADDR_LO = 8;
  localparam int PIN_A26_OR_SEL = 26;
  localparam int PIN_A27_OR_SEL = 27;
  localparam int PIN_READ_STROBE = 28;
  localparam int PIN_WRITE_STROBE = 29;
  localparam int PIN_LATCH_OR_SEL = 30;
  localparam int SELECT_ADDR_BIT = 27;

  // --------------------------------------------------------------------------
  // timing: figures in ns, counts derived from the clock period
  // --------------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int LATCH_STROBE_NS = 50;
  localparam int TURNAROUND_NS = 25;
  localparam int DATA_STROBE_NS = 100;
  localparam int HOLD_NS = 25;

  // least time rounded up, at least one cycle
  function automatic logic [3:0] ns_to_cycles(input int t_ns);
    int c;
    c = (t_ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[3:0];
  endfunction : ns_to_cycles

  localparam logic [3:0] LATCH_STROBE_CYCLES = ns_to_cycles(LATCH_STROBE_NS);
  localparam logic [3:0] TURNAROUND_CYCLES = ns_to_cycles(TURNAROUND_NS);
  localparam logic [3:0] DATA_STROBE_CYCLES = ns_to_cycles(DATA_STROBE_NS);
  localparam logic [3:0] HOLD_CYCLES = ns_to_cycles(HOLD_NS);

  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    PHASE_IDLE,
    PHASE_ADDR,
    PHASE_TURN,
    PHASE_STROBE,
    PHASE_HOLD
  } phase_t;

endpackage : host_bus_pkg

// [verilog/host_bus_pin_map.sv]
// ----------------------------------------------------------------------------
// host_bus_pin_map: places strobes, selects and address onto the port pins
// ----------------------------------------------------------------------------
// assumes all inputs but enable and select_scheme come from the sequencer's flip-flops
module host_bus_pin_map
  import host_bus_pkg::*;
(
  input wire logic enable,
  input wire logic [1:0] select_scheme,
  input wire logic latch_on,
  input wire logic read_on,
  input wire logic write_on,
  input wire logic select_on,
  input wire logic select_index,
  input wire logic drive_shared,
  input wire logic [7:0] shared_value,
  input wire logic [ADDR_WIDTH-1:0] addr,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe_n
);

  // --------------------------------------------------------------------------
  // per-scheme pin functions; strobes and selects active low, latch high
  // --------------------------------------------------------------------------
  logic sel0_n;
  logic sel1_n;
  assign sel0_n = !(select_on && !select_index);
  assign sel1_n = !(select_on && select_index);

  always_comb begin
    pin_out = '0;
    pin_oe_n = '1;
    pin_out[PIN_A27_OR_SEL:PIN_HIGH_ADDR_LO] = addr[ADDR_WIDTH-1:PIN_HIGH_ADDR_LO];
    pin_out[DATA_WIDTH-1:0] = shared_value;
    pin_out[PIN_READ_STROBE] = !read_on;
    pin_out[PIN_WRITE_STROBE] = !write_on;
    // scheme decode for the three shared pins
    unique case (select_scheme)
      SCHEME_LATCH_ONLY: begin
        pin_out[PIN_LATCH_OR_SEL] = latch_on;
      end
      SCHEME_ONE_SELECT: begin
        pin_out[PIN_A27_OR_SEL] = addr[PIN_A27_OR_SEL];
        pin_out[PIN_LATCH_OR_SEL] = !select_on;
      end
      SCHEME_TWO_SELECTS: begin
        pin_out[PIN_A27_OR_SEL] = sel1_n;
        pin_out[PIN_LATCH_OR_SEL] = sel0_n;
      end
      SCHEME_LATCH_TWO_SELECTS: begin
        pin_out[PIN_A26_OR_SEL] = sel0_n;
        pin_out[PIN_A27_OR_SEL] = sel1_n;
        pin_out[PIN_LATCH_OR_SEL] = latch_on;
      end
    endcase
    if (enable) begin
      pin_oe_n[PIN_LATCH_OR_SEL:PIN_HIGH_ADDR_LO] = '0;
      pin_oe_n[DATA_WIDTH-1:0] = {DATA_WIDTH{!drive_shared}};
    end
  end

endmodule : host_bus_pin_map

// [verilog/host_bus_8bit_muxed.sv]
// ----------------------------------------------------------------------------
// host_bus_8bit_muxed: 8-bit multiplexed host-bus sequencer for external parts
// ----------------------------------------------------------------------------
// assumes requests synchronous to sys_clk and an external latch on the bus
module host_bus_8bit_muxed
  import host_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] port_mode,
  input wire logic [1:0] host_bus_mode,
  input wire logic [1:0] select_scheme,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_WIDTH-1:0] req_addr,
  input wire logic [DATA_WIDTH-1:0] req_wdata,
  output logic resp_valid,
  output logic [DATA_WIDTH-1:0] resp_rdata,
  output logic busy,
  input wire logic [PIN_COUNT-1:0] pin_in,
  output logic [PIN_COUNT-1:0] pin_out,
  output logic [PIN_COUNT-1:0] pin_oe_n
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [3:0] count;
    logic write;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic [DATA_WIDTH-1:0] rdata;
    logic resp_valid;
    logic select_index;
  } state_t;

  state_t state;
  state_t next_state;
  logic enable;
  logic last;

  // mode decode
  assign enable = (port_mode == PORT_MODE_EIGHT_BIT_HOST_BUS) && (host_bus_mode == HB_MODE_MUXED);
  assign last = (state.count == 4'h1);
  assign req_ready = enable && (state.phase == PHASE_IDLE);
  assign resp_valid = state.resp_valid;
  assign resp_rdata = state.rdata;
  assign busy = (state.phase != PHASE_IDLE);

  // --------------------------------------------------------------------------
  // sequencer: address, turnaround, strobe, hold
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.resp_valid = 1'b0;
    unique case (state.phase)
      PHASE_IDLE: begin
        if (req_valid && req_ready) begin
          next_state.phase = PHASE_ADDR;
          next_state.count = LATCH_STROBE_CYCLES;
          next_state.write = req_write;
          next_state.addr = req_addr;
          next_state.wdata = req_wdata;
          next_state.select_index = req_addr[SELECT_ADDR_BIT];
        end
      end
      PHASE_ADDR: begin
        next_state.count = state.count - 4'h1;
        if (last) begin
          next_state.phase = PHASE_TURN;
          next_state.count = TURNAROUND_CYCLES;
        end
      end
      PHASE_TURN: begin
        next_state.count = state.count - 4'h1;
        if (last) begin
          next_state.phase = PHASE_STROBE;
          next_state.count = DATA_STROBE_CYCLES;
        end
      end
      PHASE_STROBE: begin
        next_state.count = state.count - 4'h1;
        if (last) begin
          next_state.phase = PHASE_HOLD;
          next_state.count = HOLD_CYCLES;
          if (!state.write) begin
            next_state.rdata = pin_in[DATA_WIDTH-1:0];
          end
        end
      end
      PHASE_HOLD: begin
        next_state.count = state.count - 4'h1;
        if (last) begin
          next_state.phase = PHASE_IDLE;
          next_state.count = 4'h0;
          next_state.resp_valid = 1'b1;
        end
      end
    endcase
  end

  // registered state, frozen while the clock enable is low
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= '{phase: PHASE_IDLE, default: '0};
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------------
  // pin drive: shared lines carry address then write data
  // --------------------------------------------------------------------------
  logic latch_on;
  logic strobe_on;
  logic drive_shared;
  logic [DATA_WIDTH-1:0] shared_value;
  assign latch_on = (state.phase == PHASE_ADDR);
  assign strobe_on = (state.phase == PHASE_STROBE);
  assign drive_shared = (state.phase == PHASE_ADDR) || (state.write && busy) || !busy;
  assign shared_value = (state.phase == PHASE_ADDR) ? state.addr[DATA_WIDTH-1:0] : state.wdata;

  host_bus_pin_map u_pin_map (
    .enable(enable),
    .select_scheme(select_scheme),
    .latch_on(latch_on),
    .read_on(strobe_on && !state.write),
    .write_on(strobe_on && state.write),
    .select_on(busy),
    .select_index(state.select_index && (select_scheme != SCHEME_ONE_SELECT)),
    .drive_shared(drive_shared),
    .shared_value(shared_value),
    .addr(state.addr),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n)
  );

endmodule : host_bus_8bit_muxed

// [dv/host_bus_8bit_muxed_monitor.sv]
// host_bus_8bit_muxed_monitor: pin timing checks for the muxed port
// assumes the scheme is steady per access; checks pause while clk_en is low
module host_bus_8bit_muxed_monitor
  import host_bus_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] port_mode,
  input wire logic [1:0] host_bus_mode,
  input wire logic [1:0] select_scheme,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_WIDTH-1:0] req_addr,
  input wire logic [DATA_WIDTH-1:0] req_wdata,
  input wire logic resp_valid,
  input wire logic [PIN_COUNT-1:0] pin_out,
  input wire logic [PIN_COUNT-1:0] pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  // a frozen clock enable stretches every phase, so timed checks stand down
  default disable iff (reset || !clk_en);
  logic on;
  logic ale;
  assign on = port_mode == 4'h2 && host_bus_mode == 2'h0;
  assign ale = select_scheme == 2'h0 || select_scheme == 2'h3;
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_latch; pin_out[30] [*2] ##1 !pin_out[30]; endsequence
  sequence s_read; !pin_out[28] [*4] ##1 pin_out[28]; endsequence
  sequence s_write; !pin_out[29] [*4] ##1 pin_out[29]; endsequence
  property p_refuse; !on |-> !req_ready && pin_oe_n == 32'hFFFFFFFF; endproperty
  a_refuse: assert property (p_refuse) else $error("port active while disabled");
  property p_answer; s_take |-> ##9 resp_valid; endproperty
  a_answer: assert property (p_answer) else $error("answer late or missing");
  property p_latch; s_take ##0 ale |-> ##1 s_latch; endproperty
  a_latch: assert property (p_latch) else $error("latch strobe wrong");
  property p_addr; s_take |-> ##1 pin_out[25:0] == $past(req_addr[25:0]) && pin_oe_n[7:0] == 8'h00; endproperty
  a_addr: assert property (p_addr) else $error("address phase wrong");
  property p_read; s_take ##0 !req_write |-> ##3 pin_oe_n[7:0] == 8'hFF ##1 s_read; endproperty
  a_read: assert property (p_read) else $error("read cycle wrong");
  property p_write; s_take ##0 req_write |-> ##3 pin_out[7:0] == $past(req_wdata, 3) ##1 s_write; endproperty
  a_write: assert property (p_write) else $error("write cycle wrong");
  property p_order; !pin_out[28] || !pin_out[29] |-> !(ale && pin_out[30]) && (pin_out[28] || pin_out[29]); endproperty
  a_order: assert property (p_order) else $error("strobe during latch");
  property p_sel; s_take ##0 select_scheme == 2'h2 |-> ##1 pin_out[27] != pin_out[30] && pin_out[27] == !$past(req_addr[27]); endproperty
  a_sel: assert property (p_sel) else $error("select choice wrong");
endmodule : host_bus_8bit_muxed_monitor

// [dv/host_bus_peripheral_model.sv]
// host_bus_peripheral_model: external address latch and a byte peripheral
// assumes the muxed pin map; answers reads with bytes written before
module host_bus_peripheral_model (
  input wire logic sys_clk,
  input wire logic [1:0] select_scheme,
  input wire logic [31:0] pin_out,
  output logic [31:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] addr;
  logic [7:0] last;
  logic sel_n;
  logic sel_q;
  // selected while any active select is low
  assign sel_n = select_scheme == 2'h0 ? 1'b0 : select_scheme == 2'h1 ? pin_out[30]
    : select_scheme == 2'h2 ? pin_out[30] & pin_out[27] : pin_out[26] & pin_out[27];
  // drive only under read strobe, else inverse of last so release shows
  assign pin_in = {24'h000000, (!pin_out[28] && !sel_n) ? mem[addr] : ~last};
  // latch address on strobe or select fall, store data under write strobe
  always @(posedge sys_clk) begin
    sel_q <= sel_n;
    last <= pin_in[7:0];
    if ((select_scheme == 2'h0 || select_scheme == 2'h3) ? pin_out[30] : sel_q && !sel_n) addr <= pin_out[7:0];
    if (!pin_out[29] && !sel_n) mem[addr] <= pin_out[7:0];
  end
endmodule : host_bus_peripheral_model

// [dv/host_bus_8bit_muxed_tb.sv]
// host_bus_8bit_muxed_tb: accesses per select scheme, refusal and reset
// assumes the peripheral model reads back what was written
module host_bus_8bit_muxed_tb
  import host_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------------------
  typedef struct packed {logic [1:0] sch; logic [27:0] adr; logic [7:0] dat;} row_t;
  row_t rows [4] = '{'{SCHEME_LATCH_ONLY, 28'h0000012, 8'hA5}, '{SCHEME_ONE_SELECT, 28'h1234534, 8'h3C},
    '{SCHEME_TWO_SELECTS, 28'h8000056, 8'hC3}, '{SCHEME_LATCH_TWO_SELECTS, 28'h8ABCD78, 8'h5A}};
  logic sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0, clk_en = 1'b1;
  logic [3:0] port_mode = 4'h2;
  logic [1:0] host_bus_mode = 2'h0, select_scheme = 2'h0;
  logic [ADDR_WIDTH-1:0] req_addr = 28'h0000000;
  logic [DATA_WIDTH-1:0] req_wdata = 8'h00, resp_rdata;
  logic req_ready, resp_valid, busy;
  logic [PIN_COUNT-1:0] pin_in, pin_out, pin_oe_n;
  int bad_count = 0, tests_run = 0, cycles = 0;
  host_bus_8bit_muxed i_dut (.sys_clk, .reset, .clk_en, .port_mode, .host_bus_mode, .select_scheme,
    .req_valid, .req_ready, .req_write, .req_addr, .req_wdata, .resp_valid, .resp_rdata, .busy,
    .pin_in, .pin_out, .pin_oe_n);
  host_bus_peripheral_model i_model (.sys_clk, .select_scheme, .pin_out, .pin_in);
  always #12.5 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: expected %0h got %0h", $time, exp, got);
    end
  endtask : check
  // called at a falling edge; returns at the falling edge showing the answer
  task automatic access(input logic wr, input logic [27:0] adr, input logic [7:0] dat);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = adr;
    req_wdata = dat;
    while (req_ready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (resp_valid !== 1'b1) @(negedge sys_clk);
  endtask : access
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    foreach (rows[i]) begin
      select_scheme = rows[i].sch;
      access(1'b1, rows[i].adr, rows[i].dat);
      access(1'b0, rows[i].adr, 8'h00);
      check({24'h0, rows[i].dat}, {24'h0, resp_rdata});
      $display("scheme %0d done", rows[i].sch);
    end
    // wrong port or host-bus mode: nothing taken, pins released
    for (int m = 0; m < 2; m++) begin
      port_mode = m ? 4'h2 : 4'h1;
      host_bus_mode = m ? 2'h1 : 2'h0;
      req_valid = 1'b1;
      repeat (2) @(negedge sys_clk);
      check(32'h0, {30'h0, busy, req_ready});
      check(32'hFFFFFFFF, pin_oe_n);
    end
    req_valid = 1'b0;
    port_mode = 4'h2;
    host_bus_mode = 2'h0;
    $display("refusal done");
    // clock enable low in mid read strobe: access frozen, then completes
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = 1'b0;
    repeat (5) @(negedge sys_clk);
    clk_en = 1'b0;
    req_valid = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(32'h2, {30'h0, busy, pin_out[28]});
    clk_en = 1'b1;
    while (resp_valid !== 1'b1) @(negedge sys_clk);
    check({24'h0, rows[3].dat}, {24'h0, resp_rdata});
    $display("clock enable done");
    // reset in mid write strobe, then a clean read
    @(negedge sys_clk);
    req_valid = 1'b1;
    req_write = 1'b1;
    repeat (5) @(negedge sys_clk);
    check(32'h0, {31'h0, pin_out[29]});
    req_valid = 1'b0;
    reset = 1'b1;
    @(negedge sys_clk);
    check(32'h3, {30'h0, pin_out[29:28]});
    check(32'h0, {30'h0, busy, resp_valid});
    reset = 1'b0;
    access(1'b0, rows[0].adr, 8'h00);
    check({24'h0, rows[0].dat}, {24'h0, resp_rdata});
    $display("reset done");
    stop_test();
  end
endmodule : host_bus_8bit_muxed_tb

bind host_bus_8bit_muxed host_bus_8bit_muxed_monitor i_mon (
  .sys_clk(sys_clk),
  .reset(reset),
  .clk_en(clk_en),
  .port_mode(port_mode),
  .host_bus_mode(host_bus_mode),
  .select_scheme(select_scheme),
  .req_valid(req_valid),
  .req_ready(req_ready),
  .req_write(req_write),
  .req_addr(req_addr),
  .req_wdata(req_wdata),
  .resp_valid(resp_valid),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n)
);
